// File: mac_pause_cfg.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
module mac_pause_cfg
	import mac_pause_cfg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic rx_frame_valid_i,
	input wire logic [47:0] rx_frame_dest_i,
	input wire logic [47:0] rx_frame_src_i,
	input wire logic [15:0] rx_frame_type_i,
	input wire logic [15:0] rx_frame_opcode_i,
	input wire logic [8:0] rx_pause_user_ack_i,
	output logic rx_glob_ctrl_o,
	output logic rx_prio_ctrl_o,
	output logic rx_glob_pause_o,
	output logic rx_prio_pause_o,
	output logic rx_ctrl_forward_o,
	output logic rx_ctrl_drop_o,
	output logic rx_pause_busy_o,
	output logic rx_pause_done_o,
	output logic [47:0] tx_glob_pause_dest_o,
	output logic [47:0] tx_glob_pause_source_o,
	output logic [15:0] tx_glob_pause_type_o,
	output logic [15:0] tx_glob_pause_opcode_o,
	output logic [47:0] tx_prio_pause_dest_o,
	output logic [47:0] tx_prio_pause_source_o,
	output logic [15:0] tx_prio_pause_type_o,
	output logic [15:0] tx_prio_pause_opcode_o
);

	logic [31:0] cfg_ff [0:NUM_WORDS-1];
	logic [31:0] nxt_cfg [0:NUM_WORDS-1];
	logic wr_pend_ff, nxt_wr_pend;
	logic [4:0] wr_idx_ff, nxt_wr_idx;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic hreadyout_ff;
	logic [4:0] st_last_ff, nxt_st_last;
	logic run;
	logic addr_ok;
	logic [4:0] idx;

	// Config words are those that hold settings, not control or status
	function automatic logic is_cfg(input logic [4:0] i);
		is_cfg = (i >= IDX_GC_OPC) && (i < 5'(NUM_WORDS));
	endfunction

	// Writable bits of each word
	function automatic logic [31:0] word_mask(input logic [4:0] i);
		case (i)
			IDX_CTRL: word_mask = MASK_CTRL;
			IDX_STATUS: word_mask = 32'h0000_0000;
			IDX_MCAST_HI, IDX_UCAST_HI, IDX_RXSA_HI, IDX_TGDA_HI,
			IDX_TGSA_HI, IDX_TPDA_HI, IDX_TPSA_HI: word_mask = MASK_HALF;
			default: word_mask = is_cfg(i) ? MASK_FULL : 32'h0000_0000;
		endcase
	endfunction

	// Join a low and high word pair into an address
	function automatic logic [47:0] addr48(input logic [31:0] lo,
		input logic [31:0] hi);
		addr48 = {hi[15:0], lo};
	endfunction

	logic [31:0] status_word;
	logic busy, done;

	assign run = cfg_ff[IDX_CTRL][CTRL_RUN_BIT];
	assign idx = haddr_i[6:2];
	assign addr_ok = (haddr_i[31:7] == HADDR_HI_ZERO) &&
		(idx < 5'(NUM_WORDS));
	assign status_word = {26'h000_0000, st_last_ff, busy};

	// Address phase: latch writes, fetch read data for the data phase
	always_comb begin
		nxt_wr_pend = 1'b0;
		nxt_wr_idx = wr_idx_ff;
		nxt_hrdata = 32'h0000_0000;
		if (hsel_i && hready_i && htrans_i[1] && addr_ok) begin
			if (hwrite_i) begin
				// Only whole-word writes land; narrower ones are ignored
				nxt_wr_pend = (hsize_i == HSIZE_WORD);
				nxt_wr_idx = idx;
			end else if (idx == IDX_STATUS) begin
				nxt_hrdata = status_word;
			end else begin
				nxt_hrdata = cfg_ff[idx];
			end
		end
	end

	// Data phase write; settings are frozen while traffic runs
	always_comb begin
		nxt_cfg = cfg_ff;
		if (wr_pend_ff && !(run && is_cfg(wr_idx_ff))) begin
			nxt_cfg[wr_idx_ff] = hwdata_i & word_mask(wr_idx_ff);
		end
	end

	// Last verdict flags stick until the next classified frame
	always_comb begin
		nxt_st_last = st_last_ff;
		if (rx_glob_ctrl_o || rx_prio_ctrl_o || rx_glob_pause_o ||
			rx_prio_pause_o) begin
			nxt_st_last = {rx_ctrl_forward_o, rx_prio_pause_o,
				rx_glob_pause_o, rx_prio_ctrl_o, rx_glob_ctrl_o};
		end
	end

	// Bus registers; zero wait states, so ready is low in reset and high from the first edge after it
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 5'h00;
			hrdata_ff <= 32'h0000_0000;
			hreadyout_ff <= 1'b0;
			st_last_ff <= 5'h00;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			wr_idx_ff <= nxt_wr_idx;
			hrdata_ff <= nxt_hrdata;
			hreadyout_ff <= 1'b1;
			st_last_ff <= nxt_st_last;
		end
	end

	// Settings load their defaults at reset
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cfg_ff <= WORD_RST;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	assign hrdata_o = hrdata_ff;
	assign hreadyout_o = hreadyout_ff;
	// Every access answers OKAY
	always_ff @(posedge core_clk_i) begin
		hresp_o <= 1'b0;
	end

	// Transmit pause header fields straight from the stored words
	assign tx_glob_pause_dest_o = addr48(cfg_ff[IDX_TGDA_LO],
		cfg_ff[IDX_TGDA_HI]);
	assign tx_glob_pause_source_o = addr48(cfg_ff[IDX_TGSA_LO],
		cfg_ff[IDX_TGSA_HI]);
	assign tx_glob_pause_type_o = cfg_ff[IDX_TG_FIELD][31:HALF_LSB];
	assign tx_glob_pause_opcode_o = cfg_ff[IDX_TG_FIELD][15:0];
	assign tx_prio_pause_dest_o = addr48(cfg_ff[IDX_TPDA_LO],
		cfg_ff[IDX_TPDA_HI]);
	assign tx_prio_pause_source_o = addr48(cfg_ff[IDX_TPSA_LO],
		cfg_ff[IDX_TPSA_HI]);
	assign tx_prio_pause_type_o = cfg_ff[IDX_TP_FIELD][31:HALF_LSB];
	assign tx_prio_pause_opcode_o = cfg_ff[IDX_TP_FIELD][15:0];

	// Receive classification against the stored settings
	rx_pause_classify u_classify (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(run),
		.frame_valid_i(rx_frame_valid_i),
		.frame_dest_i(rx_frame_dest_i),
		.frame_src_i(rx_frame_src_i),
		.frame_type_i(rx_frame_type_i),
		.frame_opcode_i(rx_frame_opcode_i),
		.rx_glob_ctrl_opcode_max_i(cfg_ff[IDX_GC_OPC][31:HALF_LSB]),
		.rx_glob_ctrl_opcode_min_i(cfg_ff[IDX_GC_OPC][15:0]),
		.rx_glob_ctrl_type_i(cfg_ff[IDX_CTL_TYPE][31:HALF_LSB]),
		.rx_prio_ctrl_type_i(cfg_ff[IDX_CTL_TYPE][15:0]),
		.rx_prio_ctrl_opcode_max_i(cfg_ff[IDX_PC_OPC][31:HALF_LSB]),
		.rx_prio_ctrl_opcode_min_i(cfg_ff[IDX_PC_OPC][15:0]),
		.rx_glob_pause_type_i(cfg_ff[IDX_GP_MATCH][31:HALF_LSB]),
		.rx_glob_pause_opcode_i(cfg_ff[IDX_GP_MATCH][15:0]),
		.rx_prio_pause_type_i(cfg_ff[IDX_PP_MATCH][31:HALF_LSB]),
		.rx_prio_pause_opcode_i(cfg_ff[IDX_PP_MATCH][15:0]),
		.rx_pause_multicast_dest_i(addr48(cfg_ff[IDX_MCAST_LO],
			cfg_ff[IDX_MCAST_HI])),
		.rx_pause_unicast_dest_i(addr48(cfg_ff[IDX_UCAST_LO],
			cfg_ff[IDX_UCAST_HI])),
		.rx_pause_source_addr_i(addr48(cfg_ff[IDX_RXSA_LO],
			cfg_ff[IDX_RXSA_HI])),
		.forward_en_i(cfg_ff[IDX_CTRL][CTRL_FWD_BIT]),
		.glob_ctrl_o(rx_glob_ctrl_o),
		.prio_ctrl_o(rx_prio_ctrl_o),
		.glob_pause_o(rx_glob_pause_o),
		.prio_pause_o(rx_prio_pause_o),
		.forward_o(rx_ctrl_forward_o),
		.drop_o(rx_ctrl_drop_o)
	);

	// Pause completion, optionally held for the user acknowledge
	rx_pause_ack_wait u_ack_wait (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.glob_pause_i(rx_glob_pause_o),
		.prio_pause_i(rx_prio_pause_o),
		.wait_en_i(cfg_ff[IDX_CTRL][CTRL_ACK_BIT]),
		.rx_pause_user_ack_i(rx_pause_user_ack_i),
		.busy_o(busy),
		.done_o(done)
	);

	assign rx_pause_busy_o = busy;
	assign rx_pause_done_o = done;

endmodule

// File: mac_pause_cfg_pkg.sv
// Operation
// - Global control opcode upper bound is 16 bits, default all ones.
// - Global control opcode lower bound is 16 bits, default zero.
// - Global control frames recognised by 16-bit type, default 0x8808.
// - Pause multicast destination is 48 bits, default 01-80-C2-00-00-01.
// - Pause unicast destination and source address are 48 bits, default zero.
// - Priority control frames recognised by 16-bit type, default 0x8808.
// - Priority control opcode must lie within min 0 and max 0xfff.
// - Global pause frames matched by type 0x8808 and opcode 0x0001.
// - Priority pause frames matched by type 0x8808 and opcode 0x0001.
// - Acknowledge wait on: wait on 9-bit user ack; off: ignore it.
// - Control frames forwarded when option true, dropped otherwise.
// - Sent global pause: destination 01-80-C2-00-00-01, source zero.
// - Sent global pause: type 0x8808, opcode 0x0001.
// - Sent priority pause: destination 01-80-C2-00-00-01, source zero.
// - Sent priority pause: type 0x8808, opcode 0x0001.
package mac_pause_cfg_pkg;

	// Word indices; byte address is four times the index
	localparam logic [4:0] IDX_CTRL = 5'h00;
	localparam logic [4:0] IDX_STATUS = 5'h01;
	localparam logic [4:0] IDX_GC_OPC = 5'h02;
	localparam logic [4:0] IDX_CTL_TYPE = 5'h03;
	localparam logic [4:0] IDX_PC_OPC = 5'h04;
	localparam logic [4:0] IDX_GP_MATCH = 5'h05;
	localparam logic [4:0] IDX_PP_MATCH = 5'h06;
	localparam logic [4:0] IDX_MCAST_LO = 5'h07;
	localparam logic [4:0] IDX_MCAST_HI = 5'h08;
	localparam logic [4:0] IDX_UCAST_LO = 5'h09;
	localparam logic [4:0] IDX_UCAST_HI = 5'h0a;
	localparam logic [4:0] IDX_RXSA_LO = 5'h0b;
	localparam logic [4:0] IDX_RXSA_HI = 5'h0c;
	localparam logic [4:0] IDX_TGDA_LO = 5'h0d;
	localparam logic [4:0] IDX_TGDA_HI = 5'h0e;
	localparam logic [4:0] IDX_TGSA_LO = 5'h0f;
	localparam logic [4:0] IDX_TGSA_HI = 5'h10;
	localparam logic [4:0] IDX_TG_FIELD = 5'h11;
	localparam logic [4:0] IDX_TPDA_LO = 5'h12;
	localparam logic [4:0] IDX_TPDA_HI = 5'h13;
	localparam logic [4:0] IDX_TPSA_LO = 5'h14;
	localparam logic [4:0] IDX_TPSA_HI = 5'h15;
	localparam logic [4:0] IDX_TP_FIELD = 5'h16;
	localparam int NUM_WORDS = 23;

	// Field positions
	localparam int CTRL_ACK_BIT = 0;
	localparam int CTRL_FWD_BIT = 1;
	localparam int CTRL_RUN_BIT = 2;
	localparam int HALF_LSB = 16;

	// Reserved bits never store, so they read as zero
	localparam logic [31:0] MASK_CTRL = 32'h0000_0007;
	localparam logic [31:0] MASK_HALF = 32'h0000_ffff;
	localparam logic [31:0] MASK_FULL = 32'hffff_ffff;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [15:0] GC_OPC_MAX_RST = 16'hffff;
	localparam logic [15:0] GC_OPC_MIN_RST = 16'h0000;
	localparam logic [15:0] PC_OPC_MAX_RST = 16'h0fff;
	localparam logic [15:0] PC_OPC_MIN_RST = 16'h0000;
	localparam logic [15:0] CTL_TYPE_RST = 16'h8808;
	localparam logic [15:0] PAUSE_OPC_RST = 16'h0001;
	localparam logic [47:0] MCAST_RST = 48'h0180_c200_0001;
	localparam logic [47:0] ZERO_ADDR_RST = 48'h0000_0000_0000;

	localparam logic [31:0] WORD_RST [0:NUM_WORDS-1] = '{
		CTRL_RST, 32'h0000_0000,
		{GC_OPC_MAX_RST, GC_OPC_MIN_RST},
		{CTL_TYPE_RST, CTL_TYPE_RST},
		{PC_OPC_MAX_RST, PC_OPC_MIN_RST},
		{CTL_TYPE_RST, PAUSE_OPC_RST},
		{CTL_TYPE_RST, PAUSE_OPC_RST},
		MCAST_RST[31:0], {16'h0000, MCAST_RST[47:32]},
		ZERO_ADDR_RST[31:0], {16'h0000, ZERO_ADDR_RST[47:32]},
		ZERO_ADDR_RST[31:0], {16'h0000, ZERO_ADDR_RST[47:32]},
		MCAST_RST[31:0], {16'h0000, MCAST_RST[47:32]},
		ZERO_ADDR_RST[31:0], {16'h0000, ZERO_ADDR_RST[47:32]},
		{CTL_TYPE_RST, PAUSE_OPC_RST},
		MCAST_RST[31:0], {16'h0000, MCAST_RST[47:32]},
		ZERO_ADDR_RST[31:0], {16'h0000, ZERO_ADDR_RST[47:32]},
		{CTL_TYPE_RST, PAUSE_OPC_RST}
	};

	// Bus encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [24:0] HADDR_HI_ZERO = 25'h000_0000;

	// Acknowledge wait states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT_GLOB = 2'b01,
		ST_WAIT_PRIO = 2'b10
	} ack_state_type;

endpackage

// File: rx_pause_classify.sv
`timescale 1ns/100ps
module rx_pause_classify
	import mac_pause_cfg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic frame_valid_i,
	input wire logic [47:0] frame_dest_i,
	input wire logic [47:0] frame_src_i,
	input wire logic [15:0] frame_type_i,
	input wire logic [15:0] frame_opcode_i,
	input wire logic [15:0] rx_glob_ctrl_opcode_max_i,
	input wire logic [15:0] rx_glob_ctrl_opcode_min_i,
	input wire logic [15:0] rx_glob_ctrl_type_i,
	input wire logic [15:0] rx_prio_ctrl_type_i,
	input wire logic [15:0] rx_prio_ctrl_opcode_max_i,
	input wire logic [15:0] rx_prio_ctrl_opcode_min_i,
	input wire logic [15:0] rx_glob_pause_type_i,
	input wire logic [15:0] rx_glob_pause_opcode_i,
	input wire logic [15:0] rx_prio_pause_type_i,
	input wire logic [15:0] rx_prio_pause_opcode_i,
	input wire logic [47:0] rx_pause_multicast_dest_i,
	input wire logic [47:0] rx_pause_unicast_dest_i,
	input wire logic [47:0] rx_pause_source_addr_i,
	input wire logic forward_en_i,
	output logic glob_ctrl_o,
	output logic prio_ctrl_o,
	output logic glob_pause_o,
	output logic prio_pause_o,
	output logic forward_o,
	output logic drop_o
);

	function automatic logic in_range(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	logic dest_ok;
	logic src_ok;
	logic take;
	logic nxt_gc, nxt_pc, nxt_gp, nxt_pp, nxt_fwd, nxt_drop;

	// Decode one frame header; frames are ignored while stopped
	always_comb begin
		take = frame_valid_i & run_i;
		// Zero unicast means no unicast match configured
		dest_ok = (frame_dest_i == rx_pause_multicast_dest_i) ||
			((rx_pause_unicast_dest_i != ZERO_ADDR_RST) &&
			(frame_dest_i == rx_pause_unicast_dest_i));
		// Zero source accepts any sender
		src_ok = (rx_pause_source_addr_i == ZERO_ADDR_RST) ||
			(frame_src_i == rx_pause_source_addr_i);
		nxt_gc = take && (frame_type_i == rx_glob_ctrl_type_i) &&
			in_range(frame_opcode_i, rx_glob_ctrl_opcode_min_i,
			rx_glob_ctrl_opcode_max_i);
		nxt_pc = take && (frame_type_i == rx_prio_ctrl_type_i) &&
			in_range(frame_opcode_i, rx_prio_ctrl_opcode_min_i,
			rx_prio_ctrl_opcode_max_i);
		nxt_gp = take && dest_ok && src_ok &&
			(frame_type_i == rx_glob_pause_type_i) &&
			(frame_opcode_i == rx_glob_pause_opcode_i);
		nxt_pp = take && dest_ok && src_ok &&
			(frame_type_i == rx_prio_pause_type_i) &&
			(frame_opcode_i == rx_prio_pause_opcode_i);
		nxt_fwd = (nxt_gc | nxt_pc | nxt_gp | nxt_pp) & forward_en_i;
		nxt_drop = (nxt_gc | nxt_pc | nxt_gp | nxt_pp) & ~forward_en_i;
	end

	// One-cycle verdict pulses
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			glob_ctrl_o <= 1'b0;
			prio_ctrl_o <= 1'b0;
			glob_pause_o <= 1'b0;
			prio_pause_o <= 1'b0;
			forward_o <= 1'b0;
			drop_o <= 1'b0;
		end else begin
			glob_ctrl_o <= nxt_gc;
			prio_ctrl_o <= nxt_pc;
			glob_pause_o <= nxt_gp;
			prio_pause_o <= nxt_pp;
			forward_o <= nxt_fwd;
			drop_o <= nxt_drop;
		end
	end

endmodule

// File: rx_pause_ack_wait.sv
`timescale 1ns/100ps
module rx_pause_ack_wait
	import mac_pause_cfg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic glob_pause_i,
	input wire logic prio_pause_i,
	input wire logic wait_en_i,
	input wire logic [8:0] rx_pause_user_ack_i,
	output logic busy_o,
	output logic done_o
);

	ack_state_type state_ff, nxt_state;
	logic nxt_busy, nxt_done;

	// Bit 8 acknowledges global pause, bits 7:0 the priorities
	always_comb begin
		nxt_state = state_ff;
		nxt_done = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (glob_pause_i || prio_pause_i) begin
					if (!wait_en_i) begin
						nxt_done = 1'b1;
					end else if (glob_pause_i) begin
						nxt_state = ST_WAIT_GLOB;
					end else begin
						nxt_state = ST_WAIT_PRIO;
					end
				end
			end
			ST_WAIT_GLOB: begin
				// Clearing the option releases a stuck wait
				if (!wait_en_i || rx_pause_user_ack_i[8]) begin
					nxt_state = ST_IDLE;
					nxt_done = 1'b1;
				end
			end
			ST_WAIT_PRIO: begin
				if (!wait_en_i || (|rx_pause_user_ack_i[7:0])) begin
					nxt_state = ST_IDLE;
					nxt_done = 1'b1;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_busy = (nxt_state != ST_IDLE);
	end

	// Frames seen while busy are not queued; the wait is one deep
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_ff <= ST_IDLE;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			busy_o <= nxt_busy;
			done_o <= nxt_done;
		end
	end

endmodule

// File: mac_pause_cfg_monitor.sv
`timescale 1ns/100ps
module mac_pause_cfg_monitor
	import mac_pause_cfg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic rx_frame_valid_i,
	input wire logic [8:0] rx_pause_user_ack_i,
	input wire logic rx_glob_ctrl_o,
	input wire logic rx_glob_pause_o,
	input wire logic rx_prio_pause_o,
	input wire logic rx_ctrl_forward_o,
	input wire logic rx_ctrl_drop_o,
	input wire logic rx_pause_busy_o,
	input wire logic rx_pause_done_o,
	input wire logic [47:0] tx_glob_pause_dest_o,
	input wire logic [47:0] tx_glob_pause_source_o,
	input wire logic [15:0] tx_glob_pause_type_o,
	input wire logic [15:0] tx_glob_pause_opcode_o,
	input wire logic [47:0] tx_prio_pause_dest_o,
	input wire logic [47:0] tx_prio_pause_source_o,
	input wire logic [15:0] tx_prio_pause_type_o,
	input wire logic [15:0] tx_prio_pause_opcode_o
);
	// All checks live in the core clock domain
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	// Ack arrives while waiting, then the wait ends a cycle later
	sequence ack_seen;
		rx_pause_busy_o && (&rx_pause_user_ack_i);
	endsequence
	sequence released;
		!rx_pause_busy_o && rx_pause_done_o;
	endsequence

	chk_ack_release: assert property (ack_seen |=> released)
		else $error("pause wait did not end after ack");
	chk_resp_okay: assert property (hresp_o == 1'b0)
		else $error("slave answered with an error");
	chk_ready_up: assert property (!$past(sys_rst_i) |-> hreadyout_o)
		else $error("wait state inserted");
	chk_gp_cause: assert property (rx_glob_pause_o |->
		$past(rx_frame_valid_i))
		else $error("global pause pulse without a frame");
	chk_pp_cause: assert property (rx_prio_pause_o |->
		$past(rx_frame_valid_i))
		else $error("priority pause pulse without a frame");
	chk_ctrl_verdict: assert property (rx_glob_ctrl_o |->
		(rx_ctrl_forward_o || rx_ctrl_drop_o))
		else $error("control frame got no verdict");
	chk_fwd_excl: assert property (rx_ctrl_forward_o |-> !rx_ctrl_drop_o)
		else $error("frame both forwarded and dropped");
	// Reset values must already stand at the first edge after release
	chk_tx_glob_rst: assert property ($fell(sys_rst_i) |->
		tx_glob_pause_dest_o == MCAST_RST && tx_glob_pause_source_o == 0 &&
		tx_glob_pause_type_o == CTL_TYPE_RST &&
		tx_glob_pause_opcode_o == PAUSE_OPC_RST)
		else $error("global pause fields not at reset value");
	chk_tx_prio_rst: assert property ($fell(sys_rst_i) |->
		tx_prio_pause_dest_o == MCAST_RST && tx_prio_pause_source_o == 0 &&
		tx_prio_pause_type_o == CTL_TYPE_RST &&
		tx_prio_pause_opcode_o == PAUSE_OPC_RST)
		else $error("priority pause fields not at reset value");
endmodule

bind mac_pause_cfg mac_pause_cfg_monitor mon (.core_clk_i, .sys_rst_i,
	.hreadyout_o, .hresp_o, .rx_frame_valid_i, .rx_pause_user_ack_i,
	.rx_glob_ctrl_o, .rx_glob_pause_o, .rx_prio_pause_o, .rx_ctrl_forward_o,
	.rx_ctrl_drop_o, .rx_pause_busy_o, .rx_pause_done_o,
	.tx_glob_pause_dest_o, .tx_glob_pause_source_o, .tx_glob_pause_type_o,
	.tx_glob_pause_opcode_o, .tx_prio_pause_dest_o, .tx_prio_pause_source_o,
	.tx_prio_pause_type_o, .tx_prio_pause_opcode_o);

// File: mac_pause_link_partner.sv
`timescale 1ns/100ps
module mac_pause_link_partner (
	input wire logic core_clk_i,
	output logic frame_valid_o,
	output logic [47:0] frame_dest_o,
	output logic [47:0] frame_src_o,
	output logic [15:0] frame_type_o,
	output logic [15:0] frame_opcode_o
);
	// Idle fields hold a pattern, never a plausible header
	initial begin
		frame_valid_o = 1'b0;
		frame_dest_o = 48'hffff_ffff_ffff;
		frame_src_o = 48'hffff_ffff_ffff;
		frame_type_o = 16'hffff;
		frame_opcode_o = 16'hffff;
	end

	// One header per call; fields flip once the taking edge has passed
	task frame(input logic [47:0] d, input logic [15:0] t,
		input logic [15:0] o);
		@(posedge core_clk_i);
		frame_valid_o <= 1'b1;
		frame_dest_o <= d;
		frame_src_o <= 48'h0000_0000_00a5; // Our own station address
		frame_type_o <= t;
		frame_opcode_o <= o;
		@(posedge core_clk_i);
		frame_valid_o <= 1'b0;
		frame_dest_o <= ~d;
		frame_src_o <= 48'hffff_ffff_ff5a;
		frame_type_o <= ~t;
		frame_opcode_o <= ~o;
	endtask
endmodule

// File: mac_pause_frame_config_bench.sv
`timescale 1ns/100ps
module mac_pause_frame_config_bench
	import mac_pause_cfg_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic hsel_i, hwrite_i, hreadyout_o, hresp_o, rx_frame_valid_i;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
	logic [47:0] rx_frame_dest_i, rx_frame_src_i;
	logic [47:0] tx_glob_pause_dest_o, tx_glob_pause_source_o;
	logic [47:0] tx_prio_pause_dest_o, tx_prio_pause_source_o;
	logic [15:0] rx_frame_type_i, rx_frame_opcode_i;
	logic [15:0] tx_glob_pause_type_o, tx_glob_pause_opcode_o;
	logic [15:0] tx_prio_pause_type_o, tx_prio_pause_opcode_o;
	logic [8:0] rx_pause_user_ack_i;
	logic rx_glob_ctrl_o, rx_prio_ctrl_o, rx_glob_pause_o, rx_prio_pause_o;
	logic rx_ctrl_forward_o, rx_ctrl_drop_o, rx_pause_busy_o, rx_pause_done_o;
	int miscompares = 0;
	int total_checks = 0;

	always #4 core_clk_i = ~core_clk_i;

	// Single slave, so its ready is the bus ready
	mac_pause_cfg dut (.core_clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
		.hreadyout_o, .hresp_o, .rx_frame_valid_i, .rx_frame_dest_i,
		.rx_frame_src_i, .rx_frame_type_i, .rx_frame_opcode_i,
		.rx_pause_user_ack_i, .rx_glob_ctrl_o, .rx_prio_ctrl_o,
		.rx_glob_pause_o, .rx_prio_pause_o, .rx_ctrl_forward_o,
		.rx_ctrl_drop_o, .rx_pause_busy_o, .rx_pause_done_o,
		.tx_glob_pause_dest_o, .tx_glob_pause_source_o, .tx_glob_pause_type_o,
		.tx_glob_pause_opcode_o, .tx_prio_pause_dest_o,
		.tx_prio_pause_source_o, .tx_prio_pause_type_o,
		.tx_prio_pause_opcode_o);

	mac_pause_link_partner lnk (.core_clk_i, .frame_valid_o(rx_frame_valid_i),
		.frame_dest_o(rx_frame_dest_i), .frame_src_o(rx_frame_src_i),
		.frame_type_o(rx_frame_type_i), .frame_opcode_o(rx_frame_opcode_i));

	task end_of_test;
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task cmp_val(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: value %h, want %h", $time, got, exp);
		end
	endtask

	task cmp_flags(input logic [5:0] got, input logic [5:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: flags %b, want %b", $time, got, exp);
		end
	endtask

	// One single transfer; waits for ready in both phases, no fixed latency
	task xfer(input logic [4:0] i, input logic w, input logic [31:0] d);
		@(posedge core_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {HADDR_HI_ZERO, i, 2'h0};
		hwrite_i <= w;
		hsize_i <= HSIZE_WORD;
		do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
		#1;
	endtask

	task rdchk(input logic [4:0] i, input logic [31:0] e);
		xfer(i, 1'b0, 32'h0000_0000);
		cmp_val({16'h0000, rd}, {16'h0000, e});
	endtask

	// Flags read as {drop, fwd, prio pause, glob pause, prio ctrl, glob ctrl}
	task send(input logic [47:0] d, input logic [15:0] t, input logic [15:0] o,
		input logic [5:0] e);
		lnk.frame(d, t, o);
		#1;
		cmp_flags({rx_ctrl_drop_o, rx_ctrl_forward_o, rx_prio_pause_o,
			rx_glob_pause_o, rx_prio_ctrl_o, rx_glob_ctrl_o}, e);
	endtask

	task t_defaults;
		for (int i = 0; i < NUM_WORDS; i++) begin
			rdchk(i[4:0], WORD_RST[i]);
		end
		rdchk(IDX_GC_OPC, 32'hffff_0000);
		rdchk(IDX_PC_OPC, 32'h0fff_0000);
		rdchk(5'h17, 32'h0000_0000);
		cmp_val(tx_glob_pause_dest_o, 48'h0180_c200_0001);
		cmp_val(tx_glob_pause_source_o, 48'h0000_0000_0000);
		cmp_val(tx_prio_pause_dest_o, 48'h0180_c200_0001);
		cmp_val(tx_prio_pause_source_o, 48'h0000_0000_0000);
		cmp_val({16'h0000, tx_glob_pause_type_o, tx_glob_pause_opcode_o},
			48'h0000_8808_0001);
		cmp_val({16'h0000, tx_prio_pause_type_o, tx_prio_pause_opcode_o},
			48'h0000_8808_0001);
	endtask

	task t_tx_write;
		xfer(IDX_TG_FIELD, 1'b1, 32'h1234_5678);
		rdchk(IDX_TG_FIELD, 32'h1234_5678);
		cmp_val({16'h0000, tx_glob_pause_type_o, tx_glob_pause_opcode_o},
			48'h0000_1234_5678);
		xfer(IDX_TPDA_HI, 1'b1, 32'hffff_abcd);
		cmp_val(tx_prio_pause_dest_o, 48'habcd_c200_0001);
		xfer(IDX_STATUS, 1'b1, 32'hffff_ffff);
		rdchk(IDX_STATUS, 32'h0000_0000);
	endtask

	// Wait option off: frames verdict and complete on their own
	task t_classify;
		xfer(IDX_UCAST_LO, 1'b1, 32'h0000_0002);
		xfer(IDX_CTRL, 1'b1, 32'h0000_0004);
		send(MCAST_RST, 16'h8808, 16'h0fff, 6'h23);
		send(MCAST_RST, 16'h8808, 16'h1000, 6'h21);
		send(48'h0000_0000_0002, 16'h8808, 16'h0001, 6'h2f);
		@(posedge core_clk_i);
		#1;
		cmp_flags({4'h0, rx_pause_busy_o, rx_pause_done_o}, 6'h01);
		send(MCAST_RST, 16'h0800, 16'h0001, 6'h00);
		send(48'h0180_c200_0003, 16'h8808, 16'h0001, 6'h23);
		xfer(IDX_GC_OPC, 1'b1, 32'h0000_0000);
		rdchk(IDX_GC_OPC, 32'hffff_0000);
		// Last verdict was control only, dropped, nothing waiting
		rdchk(IDX_STATUS, 32'h0000_0006);
	endtask

	// Wait option on: pause holds until the user acknowledges
	task t_ack;
		xfer(IDX_CTRL, 1'b1, 32'h0000_0007);
		send(MCAST_RST, 16'h8808, 16'h0001, 6'h1f);
		repeat (3) @(posedge core_clk_i);
		#1;
		cmp_flags({4'h0, rx_pause_busy_o, rx_pause_done_o}, 6'h02);
		rx_pause_user_ack_i <= 9'h1ff;
		@(posedge core_clk_i);
		rx_pause_user_ack_i <= 9'h000;
		#1;
		cmp_flags({4'h0, rx_pause_busy_o, rx_pause_done_o}, 6'h01);
	endtask

	// Main sequence after a 16-cycle reset
	initial begin
		hsel_i = 1'b0;
		hwrite_i = 1'b0;
		htrans_i = 2'h0;
		hsize_i = 3'h0;
		haddr_i = 32'h0000_0000;
		hwdata_i = 32'h0000_0000;
		rx_pause_user_ack_i = 9'h000;
		repeat (16) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_defaults;
		t_tx_write;
		t_classify;
		t_ack;
		end_of_test;
	end

	// Whole run needs about 140 cycles; far beyond that means a hang
	initial begin
		#100000;
		miscompares++;
		end_of_test;
	end
endmodule
